// ---- mtd_top.sv ----
`timescale 1ns/1ps
// Summary of operation
// - pulse input silent longer than auto-zero interval forces readout to zero
// - auto-zero interval accepts 0.0 to 19.9 s in tenth steps
// - auto-zero and startup delay settable only in pulse input mode
// - in pulse input mode, after reset wait the startup delay before measurement starts
// - no output is produced during the startup delay
// - startup delay accepts 0.0 to 99.9 s in tenth steps
// - switching colour modes: base colour, other colour while comparative output on
// - fixed colour modes stay green or red regardless of comparative output
// - auto-return time zero disables auto-return
// - auto-return time settable 0 to 99 whole seconds
// - no key activity for auto-return time jumps to operation level display
// - auto-return during editing stores the edited value first
// - level key held three seconds at operation level enters initial level
// - initial level shows its symbol on the level indicator
// - advanced level entered only after correct password is committed
// - advanced level shows its symbol on the level indicator
// - second shift press enters change state, value blinks
// - mode key commits edited value then shows next parameter
// - level key held one second at advanced level returns to initial level
// - level key held one second at initial level returns to operation level
module mtd_top
    import mtd_pkg::*;
#(
    parameter int TENTH_CYCLES = TENTH_CYCLES_DEF
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire mtd_keys_t   keys,
    input  wire logic [15:0] entry_value,
    input  wire logic        pulse_in,
    input  wire logic [15:0] process_value,
    input  wire logic        comp_in,
    output logic      [15:0] display_value,
    output logic             comp_out,
    output logic             measure_en,
    output logic             color_red,
    output mtd_level_t       level_ind,
    output mtd_disp_t        disp_state,
    output mtd_param_t       param_sel,
    output logic             blink
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic fits(input mtd_param_t p, input logic [15:0] v, input logic pm);
        unique case (p)
            PR_AUTOZERO: fits = pm && v <= {8'h00, AZ_MAX};
            PR_STARTUP:  fits = pm && v <= {6'h00, ST_MAX};
            PR_COLOR:    fits = v <= 16'h0003;
            PR_RETURN:   fits = v <= {9'h000, RET_MAX};
        endcase
    endfunction

    mtd_settings_t cfg_q, cfg_d;
    mtd_level_t    level_q, level_d;
    mtd_disp_t     disp_q, disp_d;
    mtd_param_t    idx_q, idx_d;
    mtd_keys_t     keys_q;
    logic [23:0]   tick_cnt_q;
    logic          tenth_q, sec_q;
    logic [3:0]    sec_cnt_q;
    logic [5:0]    hold_cnt_q;
    logic          hold_fired_q;
    logic [9:0]    st_cnt_q;
    logic          started_q;
    logic [7:0]    az_cnt_q;
    logic          pulse_prev_q, zero_q;
    logic [6:0]    ret_cnt_q;
    logic [15:0]   edit_q, disp_val_q;
    logic          comp_q, red_q, blink_q;
    logic [31:0]   prdata_q;
    logic          pready_q, pslverr_q;

    // ----------------------------------------------------------------
    // timebases
    // ----------------------------------------------------------------
    wire tick_wrap = tick_cnt_q == 24'(TENTH_CYCLES - 1);
    wire sec_wrap  = tenth_q && sec_cnt_q == TENTHS_PER_SEC - 4'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 24'h000000;
            tenth_q    <= 1'b0;
            sec_cnt_q  <= 4'h0;
            sec_q      <= 1'b0;
        end else begin
            tick_cnt_q <= tick_wrap ? 24'h000000 : tick_cnt_q + 24'h000001;
            tenth_q    <= tick_wrap;
            if (tenth_q)
                sec_cnt_q <= sec_wrap ? 4'h0 : sec_cnt_q + 4'h1;
            sec_q      <= sec_wrap;
        end
    end

    // ----------------------------------------------------------------
    // keys and level hold
    // ----------------------------------------------------------------
    wire mode_press  = keys.mode && !keys_q.mode;
    wire shift_press = keys.shift && !keys_q.shift;
    wire up_press    = keys.up && !keys_q.up;
    wire any_press   = (keys & ~keys_q) != 4'h0;
    wire in_menu     = level_q != LV_OPER;
    wire hold_ok     = keys.level && !hold_fired_q;
    wire enter_hold  = hold_ok && !in_menu && hold_cnt_q >= HOLD_ENTER_TICKS;
    wire exit_hold   = hold_ok && in_menu && hold_cnt_q >= HOLD_EXIT_TICKS;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            keys_q       <= '0;
            hold_cnt_q   <= 6'h00;
            hold_fired_q <= 1'b0;
        end else begin
            keys_q <= keys;
            if (!keys.level)
                hold_cnt_q <= 6'h00;
            else if (tenth_q && hold_cnt_q != 6'h3F)
                hold_cnt_q <= hold_cnt_q + 6'h01;
            hold_fired_q <= keys.level && (hold_fired_q || enter_hold || exit_hold);
        end
    end

    // ----------------------------------------------------------------
    // auto-return
    // ----------------------------------------------------------------
    wire ret_expire = in_menu && cfg_q.display_return_time != 7'h00
                      && ret_cnt_q > cfg_q.display_return_time;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ret_cnt_q <= 7'h00;
        else if (any_press || !in_menu)
            ret_cnt_q <= 7'h00;
        else if (sec_q && ret_cnt_q != 7'h7F)
            ret_cnt_q <= ret_cnt_q + 7'h01;
    end

    // ----------------------------------------------------------------
    // menu state and editing
    // ----------------------------------------------------------------
    wire editing  = in_menu && disp_q == DS_CHANGE;
    wire commit   = editing && (mode_press || ret_expire);
    wire pass_ok  = commit && level_q == LV_INIT && edit_q == PASSWORD;
    wire key_store = commit && level_q == LV_ADV && fits(idx_q, edit_q, cfg_q.pulse_mode);

    logic [15:0] cur_val;
    always_comb begin
        cur_val = 16'h0000;
        if (level_q == LV_ADV) begin
            unique case (idx_q)
                PR_AUTOZERO: cur_val = {8'h00, cfg_q.az};
                PR_STARTUP:  cur_val = {6'h00, cfg_q.startup_delay_time};
                PR_COLOR:    cur_val = {14'h0000, cfg_q.color};
                PR_RETURN:   cur_val = {9'h000, cfg_q.display_return_time};
            endcase
        end
    end

    always_comb begin
        level_d = level_q;
        disp_d  = disp_q;
        idx_d   = idx_q;
        if (ret_expire) begin
            level_d = LV_OPER;
            disp_d  = DS_NAME;
            idx_d   = PR_AUTOZERO;
        end else if (enter_hold) begin
            level_d = LV_INIT;
            disp_d  = DS_NAME;
            idx_d   = PR_AUTOZERO;
        end else if (exit_hold) begin
            level_d = (level_q == LV_ADV) ? LV_INIT : LV_OPER;
            disp_d  = DS_NAME;
            idx_d   = PR_AUTOZERO;
        end else if (in_menu && mode_press) begin
            disp_d = DS_NAME;
            if (level_q == LV_INIT) begin
                if (pass_ok)
                    level_d = LV_ADV;
            end else begin
                idx_d = mtd_param_t'(idx_q + 2'h1);
            end
        end else if (in_menu && shift_press) begin
            unique case (disp_q)
                DS_NAME:   disp_d = DS_VALUE;
                DS_VALUE:  disp_d = DS_CHANGE;
                DS_CHANGE: disp_d = DS_CHANGE;
                default:   disp_d = DS_NAME;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q <= LV_OPER;
            disp_q  <= DS_NAME;
            idx_q   <= PR_AUTOZERO;
            edit_q  <= 16'h0000;
            blink_q <= 1'b0;
        end else begin
            level_q <= level_d;
            disp_q  <= disp_d;
            idx_q   <= idx_d;
            if (in_menu && shift_press && disp_q == DS_VALUE)
                edit_q <= cur_val;
            else if (editing && up_press)
                edit_q <= entry_value;
            blink_q <= disp_d == DS_CHANGE && level_d != LV_OPER;
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    wire setup   = psel && !penable;
    wire addr_ok = paddr == ADDR_CFG || paddr == ADDR_AZ_TIME || paddr == ADDR_ST_TIME
                   || paddr == ADDR_RET_TIME || paddr == ADDR_STATUS;
    wire apb_wr  = psel && penable && pready_q && pwrite && addr_ok;
    wire hi_zero = pwdata[31:16] == 16'h0000;
    wire wr_az   = apb_wr && paddr == ADDR_AZ_TIME && hi_zero
                   && fits(PR_AUTOZERO, pwdata[15:0], cfg_q.pulse_mode);
    wire wr_st   = apb_wr && paddr == ADDR_ST_TIME && hi_zero
                   && fits(PR_STARTUP, pwdata[15:0], cfg_q.pulse_mode);
    wire wr_ret  = apb_wr && paddr == ADDR_RET_TIME && hi_zero
                   && fits(PR_RETURN, pwdata[15:0], cfg_q.pulse_mode);

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        unique case (paddr)
            ADDR_CFG: begin
                rd_mux[CFG_PULSE_BIT] = cfg_q.pulse_mode;
                rd_mux[CFG_COLOR_LSB +: 2] = cfg_q.color;
            end
            ADDR_AZ_TIME:  rd_mux[7:0] = cfg_q.az;
            ADDR_ST_TIME:  rd_mux[9:0] = cfg_q.startup_delay_time;
            ADDR_RET_TIME: rd_mux[6:0] = cfg_q.display_return_time;
            ADDR_STATUS: begin
                rd_mux[STAT_LEVEL_LSB +: 2] = level_q;
                rd_mux[STAT_DISP_LSB +: 2]  = disp_q;
                rd_mux[STAT_STARTED_BIT]    = started_q;
                rd_mux[STAT_ZERO_BIT]       = zero_q;
                rd_mux[STAT_RED_BIT]        = red_q;
            end
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_comb begin
        cfg_d = cfg_q;
        if (key_store) begin
            unique case (idx_q)
                PR_AUTOZERO: cfg_d.az = edit_q[7:0];
                PR_STARTUP:  cfg_d.startup_delay_time = edit_q[9:0];
                PR_COLOR:    cfg_d.color = mtd_color_t'(edit_q[1:0]);
                PR_RETURN:   cfg_d.display_return_time = edit_q[6:0];
            endcase
        end
        if (apb_wr && paddr == ADDR_CFG) begin
            cfg_d.pulse_mode = pwdata[CFG_PULSE_BIT];
            cfg_d.color      = mtd_color_t'(pwdata[CFG_COLOR_LSB +: 2]);
        end
        if (wr_az)
            cfg_d.az = pwdata[7:0];
        if (wr_st)
            cfg_d.startup_delay_time = pwdata[9:0];
        if (wr_ret)
            cfg_d.display_return_time = pwdata[6:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q     <= '{PULSE_RESET, CM_GREEN_RED, AZ_RESET, ST_RESET, RET_RESET};
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            cfg_q     <= cfg_d;
            pready_q  <= setup;
            pslverr_q <= setup && !addr_ok;
            if (setup)
                prdata_q <= addr_ok ? rd_mux : 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // startup delay, auto-zero, readout and colour
    // ----------------------------------------------------------------
    wire pulse_edge = pulse_in && !pulse_prev_q;
    wire st_done    = !cfg_q.pulse_mode || st_cnt_q >= cfg_q.startup_delay_time;
    wire zero_d     = cfg_q.pulse_mode && !pulse_edge && az_cnt_q >= cfg_q.az;

    logic red_d;
    always_comb begin
        unique case (cfg_q.color)
            CM_GREEN_RED: red_d = comp_q;
            CM_GREEN:     red_d = 1'b0;
            CM_RED_GREEN: red_d = !comp_q;
            CM_RED:       red_d = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_cnt_q     <= 10'h000;
            started_q    <= 1'b0;
            az_cnt_q     <= 8'h00;
            pulse_prev_q <= 1'b0;
            zero_q       <= 1'b0;
            disp_val_q   <= 16'h0000;
            comp_q       <= 1'b0;
            red_q        <= 1'b0;
        end else begin
            if (tenth_q && !started_q)
                st_cnt_q <= st_cnt_q + 10'h001;
            started_q    <= started_q || st_done;
            pulse_prev_q <= pulse_in;
            if (pulse_edge)
                az_cnt_q <= 8'h00;
            else if (tenth_q && az_cnt_q != 8'hFF)
                az_cnt_q <= az_cnt_q + 8'h01;
            zero_q     <= zero_d;
            disp_val_q <= (zero_d || !started_q) ? 16'h0000 : process_value;
            comp_q     <= started_q && comp_in;
            red_q      <= red_d;
        end
    end

    assign prdata        = prdata_q;
    assign pready        = pready_q;
    assign pslverr       = pslverr_q;
    assign display_value = disp_val_q;
    assign comp_out      = comp_q;
    assign measure_en    = started_q;
    assign color_red     = red_q;
    assign level_ind     = level_q;
    assign disp_state    = disp_q;
    assign param_sel     = idx_q;
    assign blink         = blink_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_zero_readout;
        @(posedge pclk) disable iff (!presetn) zero_q |-> disp_val_q == 16'h0000;
    endproperty
    a_zero_readout: assert property (p_zero_readout) else $error("readout not zero");
    property p_az_range;
        @(posedge pclk) disable iff (!presetn) cfg_q.az <= AZ_MAX;
    endproperty
    a_az_range: assert property (p_az_range) else $error("auto-zero out of range");
    property p_pulse_lock;
        @(posedge pclk) disable iff (!presetn)
            !cfg_q.pulse_mode |=> $stable(cfg_q.az) && $stable(cfg_q.startup_delay_time);
    endproperty
    a_pulse_lock: assert property (p_pulse_lock) else $error("set outside pulse mode");
    property p_no_output;
        @(posedge pclk) disable iff (!presetn) !started_q |-> !comp_q && disp_val_q == 16'h0000;
    endproperty
    a_no_output: assert property (p_no_output) else $error("output during startup");
    property p_st_range;
        @(posedge pclk) disable iff (!presetn) cfg_q.startup_delay_time <= ST_MAX;
    endproperty
    a_st_range: assert property (p_st_range) else $error("startup delay out of range");
    property p_switch_color;
        @(posedge pclk) disable iff (!presetn)
            cfg_q.color == CM_GREEN_RED |=> red_q == $past(comp_q);
    endproperty
    a_switch_color: assert property (p_switch_color) else $error("colour not switched");
    property p_fixed_red;
        @(posedge pclk) disable iff (!presetn) cfg_q.color == CM_RED |=> red_q;
    endproperty
    a_fixed_red: assert property (p_fixed_red) else $error("fixed red not red");
    property p_ret_off;
        @(posedge pclk) disable iff (!presetn)
            cfg_q.display_return_time == 7'h00 && in_menu && !exit_hold ##1 !any_press
            |-> level_q != LV_OPER;
    endproperty
    a_ret_off: assert property (p_ret_off) else $error("return while disabled");
    property p_return;
        @(posedge pclk) disable iff (!presetn) ret_expire |=> level_q == LV_OPER && !blink_q;
    endproperty
    a_return: assert property (p_return) else $error("auto-return missed");
    property p_enter_init;
        @(posedge pclk) disable iff (!presetn)
            level_q == LV_OPER ##1 level_q == LV_INIT |-> $past(hold_cnt_q) >= HOLD_ENTER_TICKS;
    endproperty
    a_enter_init: assert property (p_enter_init) else $error("early initial entry");
    property p_password;
        @(posedge pclk) disable iff (!presetn)
            level_q == LV_INIT ##1 level_q == LV_ADV |-> $past(edit_q) == PASSWORD;
    endproperty
    a_password: assert property (p_password) else $error("advanced without password");
    c_adv: cover property (@(posedge pclk) disable iff (!presetn) level_q == LV_ADV);
    c_ret: cover property (@(posedge pclk) disable iff (!presetn) ret_expire && editing);
    c_zero: cover property (@(posedge pclk) disable iff (!presetn) $rose(zero_q));
    c_start: cover property (@(posedge pclk) disable iff (!presetn) $rose(started_q));
endmodule

// ---- mtd_pkg.sv ----
package mtd_pkg;
    // ----------------------------------------------------------------
    // register map and field layout
    // ----------------------------------------------------------------
    localparam logic [7:0]  ADDR_CFG          = 8'h00;
    localparam logic [7:0]  ADDR_AZ_TIME      = 8'h04;
    localparam logic [7:0]  ADDR_ST_TIME      = 8'h08;
    localparam logic [7:0]  ADDR_RET_TIME     = 8'h0C;
    localparam logic [7:0]  ADDR_STATUS       = 8'h10;
    localparam int          CFG_PULSE_BIT     = 0;
    localparam int          CFG_COLOR_LSB     = 1;
    localparam int          STAT_LEVEL_LSB    = 0;
    localparam int          STAT_DISP_LSB     = 2;
    localparam int          STAT_STARTED_BIT  = 4;
    localparam int          STAT_ZERO_BIT     = 5;
    localparam int          STAT_RED_BIT      = 6;
    // ----------------------------------------------------------------
    // setting ranges, reset values, password
    // ----------------------------------------------------------------
    localparam logic [7:0]  AZ_MAX            = 8'hC7;
    localparam logic [9:0]  ST_MAX            = 10'h3E7;
    localparam logic [6:0]  RET_MAX           = 7'h63;
    localparam logic [7:0]  AZ_RESET          = 8'h32;
    localparam logic [9:0]  ST_RESET          = 10'h000;
    localparam logic [6:0]  RET_RESET         = 7'h00;
    localparam logic        PULSE_RESET       = 1'b1;
    localparam logic [15:0] PASSWORD          = 16'hFF57;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int          CLK_HZ            = 125_000_000;
    localparam int          TENTH_MS          = 100;
    localparam int          TENTH_CYCLES_DEF  = CLK_HZ / 1000 * TENTH_MS;
    localparam logic [3:0]  TENTHS_PER_SEC    = 4'hA;
    localparam int          HOLD_ENTER_SEC    = 3;
    localparam int          HOLD_EXIT_SEC     = 1;
    // one extra tick: the first tenth tick of a hold may come at once
    localparam logic [5:0]  HOLD_ENTER_TICKS  = 6'(HOLD_ENTER_SEC * 10 + 1);
    localparam logic [5:0]  HOLD_EXIT_TICKS   = 6'(HOLD_EXIT_SEC * 10 + 1);
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {LV_OPER = 2'b00, LV_INIT = 2'b01, LV_ADV = 2'b10} mtd_level_t;
    typedef enum logic [1:0] {DS_NAME = 2'b00, DS_VALUE = 2'b01, DS_CHANGE = 2'b10} mtd_disp_t;
    typedef enum logic [1:0] {CM_GREEN_RED = 2'b00, CM_GREEN = 2'b01,
                              CM_RED_GREEN = 2'b10, CM_RED = 2'b11} mtd_color_t;
    typedef enum logic [1:0] {PR_AUTOZERO = 2'b00, PR_STARTUP = 2'b01,
                              PR_COLOR = 2'b10, PR_RETURN = 2'b11} mtd_param_t;
    typedef struct packed {
        logic level;
        logic mode;
        logic shift;
        logic up;
    } mtd_keys_t;
    typedef struct packed {
        logic       pulse_mode;
        mtd_color_t color;
        logic [7:0] az;
        logic [9:0] startup_delay_time;
        logic [6:0] display_return_time;
    } mtd_settings_t;
endpackage

// ---- mtd_panel_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// front-panel keys and pulse source
// ----------------------------------------------------------------
module mtd_panel_model
    import mtd_pkg::*;
(
    input  wire logic pclk,
    output mtd_keys_t keys,
    output logic      pulse_in
);
    initial begin
        keys = '0;
        pulse_in = 1'b0;
    end
    // short press of one key, then idle long enough to be seen released
    task automatic tap(input int b);
        @(posedge pclk) keys[b] <= 1'b1;
        @(posedge pclk) keys[b] <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic hold(input int n);
        @(posedge pclk) keys.level <= 1'b1;
        repeat (n) @(posedge pclk);
        keys.level <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic pulse();
        @(posedge pclk) pulse_in <= 1'b1;
        @(posedge pclk) pulse_in <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
endmodule

// ---- tb_mtd_top.sv ----
`timescale 1ns/1ps
module tb_mtd_top
    import mtd_pkg::*;
;
    localparam int TC = 20;
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] x;
        logic        e;
    } mtd_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        comp_in, pulse_in, comp_out, measure_en, color_red, blink;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] entry_value, process_value, display_value;
    mtd_keys_t   keys;
    mtd_level_t  level_ind;
    mtd_disp_t   disp_state;
    mtd_param_t  param_sel;
    int          error_cnt = 0;
    int          checks = 0;
    mtd_row_t    rows [16] = '{
        '{0, 8'h00, 0, 1, 0}, '{0, 8'h04, 0, 32'h32, 0}, '{0, 8'h08, 0, 0, 0},
        '{0, 8'h0C, 0, 0, 0}, '{1, 8'h04, 32'hC7, 0, 0}, '{1, 8'h04, 32'hC8, 0, 0},
        '{0, 8'h04, 0, 32'hC7, 0}, '{1, 8'h08, 32'h3E7, 0, 0}, '{1, 8'h08, 32'h3E8, 0, 0},
        '{0, 8'h08, 0, 32'h3E7, 0}, '{1, 8'h0C, 32'h64, 0, 0}, '{0, 8'h0C, 0, 0, 0},
        '{0, 8'h14, 0, 0, 1}, '{1, 8'h00, 0, 0, 0}, '{1, 8'h04, 5, 0, 0},
        '{0, 8'h04, 0, 32'hC7, 0}};

    mtd_top #(.TENTH_CYCLES(TC)) mtd_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .keys(keys), .entry_value(entry_value),
        .pulse_in(pulse_in), .process_value(process_value), .comp_in(comp_in),
        .display_value(display_value), .comp_out(comp_out), .measure_en(measure_en),
        .color_red(color_red), .level_ind(level_ind), .disp_state(disp_state),
        .param_sel(param_sel), .blink(blink));
    mtd_panel_model panel_inst (.pclk(pclk), .keys(keys), .pulse_in(pulse_in));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic stop_test();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            stop_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic edit(input logic [15:0] v);
        panel_inst.tap(1);
        panel_inst.tap(1);
        entry_value <= v;
        panel_inst.tap(0);
        chk(disp_state === DS_CHANGE && blink === 1'b1, "change state");
    endtask
    task automatic enter_adv();
        panel_inst.hold(35 * TC);
        chk(level_ind === LV_INIT, "initial level");
        edit(PASSWORD);
        panel_inst.tap(2);
        chk(level_ind === LV_ADV && param_sel === PR_AUTOZERO, "advanced level");
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, comp_in} = '0;
        paddr = '0;
        pwdata = '0;
        entry_value = '0;
        process_value = 16'h1234;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(measure_en === 1'b1, "measure enable");
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(rd === rows[i].x && er === rows[i].e, "register row");
        end
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < 2; k++) begin
                apb(1'b1, 8'h00, 32'(c * 2 + 1));
                comp_in <= k[0];
                repeat (3) @(posedge pclk);
                chk(color_red === (c[0] ? c[1] : c[1] ^ k[0]), "colour");
                chk(comp_out === k[0], "comparative output");
            end
        end
        // pulse mode is back on, so a short auto-zero interval is accepted
        apb(1'b1, 8'h04, 32'h5);
        repeat (6 * TC) @(posedge pclk);
        chk(display_value === 16'h0000, "idle zero");
        panel_inst.pulse();
        chk(display_value === 16'h1234, "pulse shown");
        repeat (7 * TC) @(posedge pclk);
        chk(display_value === 16'h0000, "forced zero");
        panel_inst.hold(25 * TC);
        chk(level_ind === LV_OPER, "short hold ignored");
        enter_adv();
        edit(16'h0009);
        panel_inst.tap(2);
        chk(param_sel === PR_STARTUP, "next parameter");
        apb(1'b0, 8'h04, 0);
        chk(rd === 32'h9, "committed value");
        repeat (60 * TC) @(posedge pclk);
        chk(level_ind === LV_ADV, "return disabled");
        panel_inst.hold(15 * TC);
        chk(level_ind === LV_INIT, "back to initial");
        panel_inst.hold(15 * TC);
        chk(level_ind === LV_OPER, "back to operation");
        apb(1'b1, 8'h0C, 1);
        enter_adv();
        edit(16'h0004);
        repeat (25 * TC) @(posedge pclk);
        chk(level_ind === LV_OPER, "auto return");
        apb(1'b0, 8'h04, 0);
        chk(rd === 32'h4, "stored on return");
        // mid-run reset: outputs quiet while held, measurement restarts after
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(measure_en === 1'b0 && display_value === 16'h0000, "reset quiet");
        chk(level_ind === LV_OPER, "reset level");
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(measure_en === 1'b1, "measure after reset");
        stop_test();
    end
endmodule
